// [verilog/srp_spi_port.v]
// serial register port: command decode, paged register words, fifo drain
// assumes the serial pins come from an external master on its own clock;
// converter results arrive on the system clock
`timescale 1ns/1ps
`default_nettype none
`include "srp_consts.vh"

module srp_spi_port #(
  parameter integer DATA_W  = 12,
  parameter integer DEPTH_W = 6
) (
  input  wire              CLK_SYS_IN,
  input  wire              RST_B_IN,
  input  wire              SCLK_IN,
  input  wire              SS_B_IN,
  input  wire              MOSI_IN,
  input  wire              POWER_DOWN_B_IN,
  input  wire              RESULT_VALID_IN,
  input  wire [2:0]        RESULT_CHANNEL_IN,
  input  wire [DATA_W-1:0] RESULT_DATA_IN,
  output reg               MISO_OUT,
  output reg               MISO_OE_OUT,
  output reg               RESULT_READY_IRQ_B_OUT,
  output reg               CONV_START_OUT,
  output reg  [3:0]        CONV_INPUT_SELECT_OUT,
  output reg               POWER_DOWN_OUT
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg  [2:0] sync1;
  reg  [2:0] sync2;
  reg  [2:0] sync3;
  reg  [2:0] pin;
  reg  [2:0] pin_prev;
  wire [2:0] pin_raw = {POWER_DOWN_B_IN, SS_B_IN, SCLK_IN};

  // three stages per pin; a change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
          sync1[g]    <= (g == 0) ? 1'b0 : 1'b1;  // idle level, no false edge
          sync2[g]    <= (g == 0) ? 1'b0 : 1'b1;
          sync3[g]    <= (g == 0) ? 1'b0 : 1'b1;
          pin[g]      <= (g == 0) ? 1'b0 : 1'b1;
          pin_prev[g] <= (g == 0) ? 1'b0 : 1'b1;
        end else begin
          sync1[g]    <= pin_raw[g];
          sync2[g]    <= sync1[g];
          sync3[g]    <= sync2[g];
          pin_prev[g] <= pin[g];
          if (sync2[g] == sync3[g]) begin
            pin[g] <= sync3[g];
          end
        end
      end
    end
  endgenerate

  // mosi is only looked at on a clock edge, long after it settled
  reg mosi_s1;
  reg mosi_s2;
  reg mosi_s3;
  always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      mosi_s3 <= 1'b0;
    end else begin
      mosi_s1 <= MOSI_IN;
      mosi_s2 <= mosi_s1;
      mosi_s3 <= mosi_s2;
    end
  end

  wire sclk_rise = pin[0] && !pin_prev[0];
  wire sclk_fall = !pin[0] && pin_prev[0];
  wire ss_fall   = !pin[1] && pin_prev[1];
  wire ss_active = !pin[1];

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [15:0]     ctrl_a [0:63];
  reg [15:0]     ctrl_b [0:63];
  reg [15:0]     result_word [0:4];
  reg [15:0]     rx_shift;
  reg [15:0]     tx_shift;
  reg [3:0]      bit_count;
  reg            in_command;
  reg            framed;
  reg            read_dir;
  reg [3:0]      page;
  reg [5:0]      index;
  reg            past_end;
  reg            load_pending;
  reg            buf_clear;
  reg            buf_pop;
  reg            pop_armed;

  wire [15:0] buf_mode = ctrl_a[`SRP_IDX_BUF_MODE];
  wire        buf_on   = buf_mode[`SRP_BUF_ENABLE_BIT];

  wire [DATA_W-1:0] fifo_data;
  wire              fifo_empty;
  wire              fifo_full;
  wire              fifo_irq;
  wire              fifo_start;

  // page decode shared by read mux and write path
  function page_valid;
    input [3:0] p;
    begin
      page_valid = (p <= `SRP_PAGE_BUFFER);
    end
  endfunction

  // result page: five result words, other indices reserved
  function [2:0] result_slot;
    input [5:0] idx;
    begin
      case (idx)
        `SRP_IDX_BATTERY:   result_slot = `SRP_CH_BATTERY;
        `SRP_IDX_AUX_ONE:   result_slot = `SRP_CH_AUX_ONE;
        `SRP_IDX_AUX_TWO:   result_slot = `SRP_CH_AUX_TWO;
        `SRP_IDX_TEMP_LOW:  result_slot = `SRP_CH_TEMP_LOW;
        `SRP_IDX_TEMP_HIGH: result_slot = `SRP_CH_TEMP_HIGH;
        default:            result_slot = 3'h7;
      endcase
    end
  endfunction

  // ----------------------------------------
  // read data selection
  // ----------------------------------------
  reg [15:0] read_word;
  reg [2:0]  slot;
  always @* begin
    read_word = `SRP_RESERVED_WORD;
    slot      = result_slot(index);
    if (past_end) begin
      read_word = `SRP_PAST_END_WORD;
    end else if (page_valid(page)) begin
      case (page)
        `SRP_PAGE_RESULT: begin
          if (slot != 3'h7) begin
            read_word = result_word[slot];
          end
        end
        `SRP_PAGE_CTRL_A: begin
          read_word = ctrl_a[index];
          if (index == `SRP_IDX_BUF_MODE) begin
            read_word[`SRP_BUF_FULL_BIT]  = fifo_full;
            read_word[`SRP_BUF_EMPTY_BIT] = fifo_empty;
            read_word[`SRP_BUF_RESET_BIT] = 1'b0;
          end
        end
        `SRP_PAGE_CTRL_B: begin
          read_word = ctrl_b[index];
        end
        `SRP_PAGE_BUFFER: begin
          read_word = {fifo_empty, fifo_full, {(14-DATA_W){1'b0}}, fifo_data};
        end
        default: begin
          read_word = `SRP_RESERVED_WORD;
        end
      endcase
    end
  end

  // ----------------------------------------
  // serial word engine
  // ----------------------------------------
  // samples on falling sclk, drives on rising sclk (idle low, second phase)
  wire [15:0] word_in = {rx_shift[14:0], mosi_s3};
  integer i;
  integer j;
  always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rx_shift     <= 16'h0000;
      tx_shift     <= 16'h0000;
      bit_count    <= 4'h0;
      in_command   <= 1'b1;
      framed       <= 1'b0;
      read_dir     <= 1'b0;
      page         <= 4'h0;
      index        <= 6'h00;
      past_end     <= 1'b0;
      load_pending <= 1'b0;
      buf_clear    <= 1'b0;
      buf_pop      <= 1'b0;
      pop_armed    <= 1'b0;
      MISO_OUT     <= 1'b0;
      MISO_OE_OUT  <= 1'b0;
      for (i = 0; i < 64; i = i + 1) begin
        ctrl_a[i] <= `SRP_RESET_WORD;
        ctrl_b[i] <= `SRP_RESET_WORD;
      end
    end else begin
      buf_clear    <= 1'b0;
      buf_pop      <= 1'b0;
      load_pending <= 1'b0;
      MISO_OE_OUT  <= ss_active;
      // only a falling select opens a frame; select held low keeps it
      if (ss_fall) begin
        framed     <= 1'b1;
        in_command <= 1'b1;
        bit_count  <= 4'h0;
        tx_shift   <= 16'h0000;
        past_end   <= 1'b0;
        pop_armed  <= 1'b0;
      end else if (!ss_active) begin
        framed <= 1'b0;
      end else if (framed && sclk_fall) begin
        rx_shift  <= word_in;
        bit_count <= bit_count + 1'b1;
        if (bit_count == `SRP_WORD_LAST_BIT) begin
          if (in_command) begin
            in_command <= 1'b0;
            read_dir   <= word_in[`SRP_CMD_RW_BIT];
            page       <= word_in[`SRP_CMD_PAGE_HI:`SRP_CMD_PAGE_LO];
            index      <= word_in[`SRP_CMD_INDEX_HI:`SRP_CMD_INDEX_LO];
            load_pending <= word_in[`SRP_CMD_RW_BIT];
          end else begin
            // write path: data words land at the current index
            if (!read_dir && !past_end && page_valid(page)) begin
              case (page)
                `SRP_PAGE_CTRL_A: begin
                  ctrl_a[index] <= word_in;
                  if (index == `SRP_IDX_BUF_MODE) begin
                    buf_clear <= word_in[`SRP_BUF_RESET_BIT];
                  end
                end
                `SRP_PAGE_CTRL_B: ctrl_b[index] <= word_in;
                default: ;
              endcase
            end
            if (index == `SRP_INDEX_LAST) begin
              past_end <= 1'b1;
            end else begin
              index <= index + 1'b1;
            end
            load_pending <= read_dir;
          end
        end
      end else if (framed && sclk_rise) begin
        MISO_OUT <= tx_shift[15];
        tx_shift <= {tx_shift[14:0], 1'b0};
        buf_pop   <= pop_armed;
        pop_armed <= 1'b0;
      end
      // fetch the next word before the next rising edge of sclk
      if (load_pending) begin
        tx_shift <= read_word;
        pop_armed <= (page == `SRP_PAGE_BUFFER) && !past_end;  // pop once shifted, not on prefetch
      end
    end
  end

  // ----------------------------------------
  // result words, outputs and power-down
  // ----------------------------------------
  // power-down only reports; nothing clears register contents
  always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      for (j = 0; j < 5; j = j + 1) begin
        result_word[j] <= `SRP_RESET_WORD;
      end
      RESULT_READY_IRQ_B_OUT <= 1'b1;
      CONV_START_OUT         <= 1'b0;
      CONV_INPUT_SELECT_OUT  <= 4'h0;
      POWER_DOWN_OUT         <= 1'b0;
    end else begin
      if (RESULT_VALID_IN && (RESULT_CHANNEL_IN <= `SRP_CH_TEMP_HIGH)) begin
        result_word[RESULT_CHANNEL_IN] <= {{(16-DATA_W){1'b0}}, RESULT_DATA_IN};
      end
      RESULT_READY_IRQ_B_OUT <= !fifo_irq;
      CONV_START_OUT         <= fifo_start;
      CONV_INPUT_SELECT_OUT  <= ctrl_a[`SRP_IDX_CONV_CTRL][`SRP_CONV_SEL_HI:`SRP_CONV_SEL_LO];
      POWER_DOWN_OUT         <= !pin[2];
    end
  end

  // ----------------------------------------
  // measurement buffer
  // ----------------------------------------
  srp_meas_fifo #(
    .DATA_W  (DATA_W),
    .DEPTH_W (DEPTH_W)
  ) u_fifo (
    .clk_in         (CLK_SYS_IN),
    .rst_b_in       (RST_B_IN),
    .clear_in       (buf_clear),
    .continuous_in  (buf_mode[`SRP_BUF_CONT_BIT]),
    .trig_level_in  (buf_mode[`SRP_BUF_TRIG_HI:`SRP_BUF_TRIG_LO]),
    .push_in        (RESULT_VALID_IN && buf_on),
    .push_data_in   (RESULT_DATA_IN),
    .pop_in         (buf_pop),
    .pop_data_out   (fifo_data),
    .empty_out      (fifo_empty),
    .full_out       (fifo_full),
    .irq_out        (fifo_irq),
    .start_conv_out (fifo_start)
  );

endmodule // srp_spi_port

`default_nettype wire

// [verilog/srp_consts.vh]
// constants for the serial register port and measurement result fifo
// assumes inclusion by the design files only; holds definitions only
`ifndef SRP_CONSTS_VH
`define SRP_CONSTS_VH

// ----------------------------------------
// command word layout
// ----------------------------------------
`define SRP_CMD_RW_BIT      15
`define SRP_CMD_PAGE_HI     14
`define SRP_CMD_PAGE_LO     11
`define SRP_CMD_INDEX_HI    10
`define SRP_CMD_INDEX_LO    5
`define SRP_WORD_LAST_BIT   4'hF

// ----------------------------------------
// pages and indices
// ----------------------------------------
`define SRP_PAGE_RESULT     4'h0
`define SRP_PAGE_CTRL_A     4'h1
`define SRP_PAGE_CTRL_B     4'h2
`define SRP_PAGE_BUFFER     4'h3
`define SRP_INDEX_LAST      6'h3F
`define SRP_IDX_CONV_CTRL   6'h00
`define SRP_IDX_BUF_MODE    6'h02
`define SRP_IDX_BATTERY     6'h05
`define SRP_IDX_AUX_ONE     6'h07
`define SRP_IDX_AUX_TWO     6'h08
`define SRP_IDX_TEMP_LOW    6'h09
`define SRP_IDX_TEMP_HIGH   6'h0A
`define SRP_PAST_END_WORD   16'hFFFF
`define SRP_RESERVED_WORD   16'h0000
`define SRP_RESET_WORD      16'h0000

// ----------------------------------------
// converter channel tags
// ----------------------------------------
`define SRP_CH_BATTERY      3'h0
`define SRP_CH_AUX_ONE      3'h1
`define SRP_CH_AUX_TWO      3'h2
`define SRP_CH_TEMP_LOW     3'h3
`define SRP_CH_TEMP_HIGH    3'h4

// ----------------------------------------
// buffer mode and conversion control register fields
// ----------------------------------------
`define SRP_BUF_ENABLE_BIT  15
`define SRP_BUF_CONT_BIT    14
`define SRP_BUF_RESET_BIT   13
`define SRP_BUF_FULL_BIT    12
`define SRP_BUF_EMPTY_BIT   11
`define SRP_BUF_TRIG_HI     5
`define SRP_BUF_TRIG_LO     0
`define SRP_CONV_SEL_HI     13
`define SRP_CONV_SEL_LO     10

// ----------------------------------------
// fifo data word flags and fifo start position
// ----------------------------------------
`define SRP_FIFO_EMPTY_BIT  15
`define SRP_FIFO_FULL_BIT   14
`define SRP_FIFO_START_POS  6'h01

`endif

// [verilog/srp_meas_fifo.v]
// circular result buffer with read, write and trigger positions
// assumes push, pop and controls come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "srp_consts.vh"

module srp_meas_fifo #(
  parameter integer DATA_W  = 12,
  parameter integer DEPTH_W = 6
) (
  input  wire               clk_in,
  input  wire               rst_b_in,
  input  wire               clear_in,
  input  wire               continuous_in,
  input  wire [DEPTH_W-1:0] trig_level_in,
  input  wire               push_in,
  input  wire [DATA_W-1:0]  push_data_in,
  input  wire               pop_in,
  output wire [DATA_W-1:0]  pop_data_out,
  output wire               empty_out,
  output wire               full_out,
  output reg                irq_out,
  output reg                start_conv_out
);

  localparam [DEPTH_W:0] DEPTH = {1'b1, {DEPTH_W{1'b0}}};

  reg [DATA_W-1:0]  mem [0:DEPTH-1];
  reg [DEPTH_W-1:0] fifo_write_position;
  reg [DEPTH_W-1:0] fifo_read_position;
  reg [DEPTH_W-1:0] fifo_trigger_position;
  reg [DEPTH_W:0]   count;
  reg               waiting_read;
  reg               cont_pending;

  wire full_now  = (count == DEPTH);
  wire trig_hit  = push_in && (fifo_write_position == fifo_trigger_position);
  wire do_pop    = pop_in && (count != {(DEPTH_W+1){1'b0}});

  assign pop_data_out = mem[fifo_read_position];
  assign empty_out    = (count == {(DEPTH_W+1){1'b0}});
  assign full_out     = full_now;

  // storage; a full buffer overwrites the next location
  always @(posedge clk_in) begin
    if (push_in) begin
      mem[fifo_write_position] <= push_data_in;
    end
  end

  // positions, count and trigger handling
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fifo_write_position   <= `SRP_FIFO_START_POS;
      fifo_read_position    <= `SRP_FIFO_START_POS;
      fifo_trigger_position <= {DEPTH_W{1'b0}};
      count                 <= {(DEPTH_W+1){1'b0}};
      irq_out               <= 1'b0;
      waiting_read          <= 1'b0;
      cont_pending          <= 1'b0;
      start_conv_out        <= 1'b0;
    end else if (clear_in) begin
      fifo_write_position   <= `SRP_FIFO_START_POS;
      fifo_read_position    <= `SRP_FIFO_START_POS;
      fifo_trigger_position <= trig_level_in;
      count                 <= {(DEPTH_W+1){1'b0}};
      irq_out               <= 1'b0;
      waiting_read          <= 1'b0;
      cont_pending          <= 1'b0;
      start_conv_out        <= 1'b0;
    end else begin
      start_conv_out <= 1'b0;
      if (push_in) begin
        fifo_write_position <= fifo_write_position + 1'b1;
      end
      // full and pushing: oldest entry is lost, read position follows
      if (push_in && full_now && !do_pop) begin
        fifo_read_position <= fifo_read_position + 1'b1;
      end else if (do_pop) begin
        fifo_read_position <= fifo_read_position + 1'b1;
      end
      // reading an empty buffer leaves the read position alone
      if (push_in && !full_now && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !push_in) begin
        count <= count - 1'b1;
      end
      // trigger: set wins over a read or write clear in the same cycle; clear_in wins over set
      if (trig_hit) begin
        irq_out <= 1'b1;
        if (continuous_in) begin
          fifo_trigger_position <= fifo_trigger_position + trig_level_in;
          start_conv_out        <= 1'b1;
          cont_pending          <= 1'b1;
          waiting_read          <= 1'b0;
        end else begin
          waiting_read <= 1'b1;
          cont_pending <= 1'b0;
        end
      end else if (waiting_read && pop_in) begin
        irq_out               <= 1'b0;
        start_conv_out        <= 1'b1;
        fifo_trigger_position <= fifo_trigger_position + trig_level_in;
        waiting_read          <= 1'b0;
      end else if (cont_pending && (push_in || pop_in)) begin
        irq_out      <= 1'b0;
        cont_pending <= 1'b0;
      end
    end
  end

endmodule // srp_meas_fifo

`default_nettype wire

// [testbench/srp_spi_port_asserts.sv]
// concurrent checks on the serial register port top level
// assumes it is bound to srp_spi_port and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module srp_spi_port_asserts (
  input wire logic       CLK_SYS_IN,
  input wire logic       RST_B_IN,
  input wire logic       SCLK_IN,
  input wire logic       SS_B_IN,
  input wire logic       POWER_DOWN_B_IN,
  input wire logic       RESULT_VALID_IN,
  input wire logic       MISO_OUT,
  input wire logic       MISO_OE_OUT,
  input wire logic       RESULT_READY_IRQ_B_OUT,
  input wire logic       CONV_START_OUT,
  input wire logic [3:0] CONV_INPUT_SELECT_OUT,
  input wire logic       POWER_DOWN_OUT
);
  // cycles since the raw link clock last moved, saturating
  logic [3:0] edge_age;
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN)
      edge_age <= 4'hF;
    else if ($changed(SCLK_IN))
      edge_age <= 4'h0;
    else if (edge_age != 4'hF)
      edge_age <= edge_age + 4'h1;
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_B_IN);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_reset_quiet: assert property ($rose(RST_B_IN) |-> RESULT_READY_IRQ_B_OUT && !MISO_OE_OUT)
    else $error("outputs not idle after reset");
  a_oe_on_select: assert property ($fell(SS_B_IN) |-> ##[1:6] MISO_OE_OUT)
    else $error("data out not enabled after select");
  a_oe_released: assert property (SS_B_IN [*6] |-> !MISO_OE_OUT)
    else $error("data out still enabled without select");
  a_miso_on_edge: assert property (!SS_B_IN [*8] ##0 $changed(MISO_OUT) |-> edge_age <= 4'h9)
    else $error("data out moved away from a link clock edge");
  a_start_pulse: assert property (CONV_START_OUT |=> !CONV_START_OUT)
    else $error("conversion start longer than one cycle");
  a_irq_cause: assert property ($fell(RESULT_READY_IRQ_B_OUT) |->
      $past(RESULT_VALID_IN, 1) || $past(RESULT_VALID_IN, 2) || $past(RESULT_VALID_IN, 3))
    else $error("interrupt raised without a stored result");
  a_pdn_follow: assert property (!POWER_DOWN_B_IN [*6] |-> POWER_DOWN_OUT)
    else $error("power-down not reported");
  a_pdn_release: assert property (POWER_DOWN_B_IN [*6] |-> !POWER_DOWN_OUT)
    else $error("power-down reported while pin high");
  a_select_write: assert property ($changed(CONV_INPUT_SELECT_OUT) |-> !$past(SS_B_IN, 4))
    else $error("input select changed outside a frame");
endmodule // srp_spi_port_asserts

bind srp_spi_port srp_spi_port_asserts chk_u (
  .CLK_SYS_IN(CLK_SYS_IN), .RST_B_IN(RST_B_IN), .SCLK_IN(SCLK_IN), .SS_B_IN(SS_B_IN),
  .POWER_DOWN_B_IN(POWER_DOWN_B_IN), .RESULT_VALID_IN(RESULT_VALID_IN),
  .MISO_OUT(MISO_OUT), .MISO_OE_OUT(MISO_OE_OUT),
  .RESULT_READY_IRQ_B_OUT(RESULT_READY_IRQ_B_OUT), .CONV_START_OUT(CONV_START_OUT),
  .CONV_INPUT_SELECT_OUT(CONV_INPUT_SELECT_OUT), .POWER_DOWN_OUT(POWER_DOWN_OUT)
);
`default_nettype wire

// [testbench/srp_spi_master.sv]
// behavioural serial bus master, clock idle low, data on rising edge
// assumes its caller runs tasks one at a time off the system clock
`timescale 1ns/1ps
`default_nettype none
module srp_spi_master (
  input  wire logic clk_in,
  input  wire logic miso_in,
  output var  logic sclk_out,
  output var  logic ss_b_out,
  output var  logic mosi_out
);
  int half = 10; // system cycles per half link period; raise for a slow host

  // idle: clock low, no select
  initial begin
    sclk_out = 1'b0;
    ss_b_out = 1'b1;
    mosi_out = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // select falls with the clock low, so the next word is a command
  task automatic open_frame;
    wait_n(1);
    ss_b_out = 1'b0;
    wait_n(half);
  endtask

  // released data line flips so a held value is never mistaken for data
  task automatic close_frame;
    wait_n(half);
    ss_b_out = 1'b1;
    mosi_out = ~mosi_out;
    wait_n(2 * half);
  endtask

  // one word msb first: drive on the rising edge, sample on the falling edge
  task automatic word(input logic [15:0] tx, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--) begin
      wait_n(1);
      sclk_out = 1'b1;
      mosi_out = tx[i];
      wait_n(half);
      sclk_out = 1'b0;
      rx[i] = miso_in;
      wait_n(half - 1);
    end
  endtask
endmodule // srp_spi_master
`default_nettype wire

// [testbench/test_srp_spi_port.sv]
// self-checking bench for the serial register port and result buffer
// assumes the master model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module test_srp_spi_port;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        pdn_b = 1'b1;
  logic        valid = 1'b0;
  logic [2:0]  chan = 3'h0;
  logic [11:0] data = 12'h000;
  wire         sclk, ss_b, mosi, miso, miso_oe, irq_b, conv_start, pdn;
  wire  [3:0]  sel;
  logic [15:0] tx_w [0:3];
  logic [15:0] rx_w [0:3];
  int          miscompares = 0;
  int          tests_run = 0;
  int          starts = 0;

  srp_spi_port dut_u (
    .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .SCLK_IN(sclk), .SS_B_IN(ss_b), .MOSI_IN(mosi),
    .POWER_DOWN_B_IN(pdn_b), .RESULT_VALID_IN(valid), .RESULT_CHANNEL_IN(chan),
    .RESULT_DATA_IN(data), .MISO_OUT(miso), .MISO_OE_OUT(miso_oe),
    .RESULT_READY_IRQ_B_OUT(irq_b), .CONV_START_OUT(conv_start),
    .CONV_INPUT_SELECT_OUT(sel), .POWER_DOWN_OUT(pdn)
  );
  srp_spi_master m_u (
    .clk_in(clk), .miso_in(miso), .sclk_out(sclk), .ss_b_out(ss_b), .mosi_out(mosi)
  );

  initial begin
    forever #2 clk = ~clk;
  end
  // conversion start pulses, counted for the buffer scenarios
  always @(posedge clk) begin
    if (conv_start === 1'b1)
      starts++;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // command then n data words from tx_w, answers land in rx_w
  task automatic frame(input logic [15:0] cmd, input int n);
    logic [15:0] r;
    m_u.open_frame();
    m_u.word(cmd, r);
    check("command echo", r, 16'h0000);
    for (int k = 0; k < n; k++)
      m_u.word(tx_w[k], rx_w[k]);
    m_u.close_frame();
  endtask

  // one converter result, channel cycling over all five inputs
  task automatic push(input logic [11:0] d);
    @(negedge clk);
    valid = 1'b1;
    data = d;
    chan = 3'(d % 12'd5);
    @(negedge clk);
    valid = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_regs;
    tx_w = '{16'h0400, 16'h0800, 16'h3C00, 16'h0000};
    frame(16'h0800, 3); // third word proves the select stayed low as data
    check("input select", {12'h0, sel}, 16'h0001);
    frame(16'h8800, 1);
    check("page1 word0", rx_w[0], 16'h0400);
    frame(16'h8000, 1);
    check("page0 word0", rx_w[0], 16'h0000);
    frame(16'h8FE0, 2);
    check("past page end", rx_w[1], 16'hFFFF);
    tx_w[0] = 16'hFFFF;
    frame(16'h2800, 1);
    check("reserved write", {12'h0, sel}, 16'h0001);
    frame(16'hA000, 1);
    check("reserved read", rx_w[0], 16'h0000);
  endtask

  task automatic s_single;
    int s;
    tx_w[0] = 16'hA002;
    frame(16'h0840, 1);
    push(12'h111);
    check("irq early", {15'h0, irq_b}, 16'h0001);
    push(12'h222);
    check("irq at level", {15'h0, irq_b}, 16'h0000);
    s = starts;
    frame(16'h9800, 3);
    check("first entry", rx_w[0], 16'h0111);
    check("second entry", rx_w[1], 16'h0222);
    check("empty flag", {15'h0, rx_w[2][15]}, 16'h0001);
    check("irq on read", {15'h0, irq_b}, 16'h0001);
    check("restart", 16'(starts - s), 16'h0001);
    push(12'h333);
    frame(16'h9800, 1);
    check("after empty read", rx_w[0], 16'h0333);
  endtask

  task automatic s_cont;
    int s;
    tx_w[0] = 16'hE002;
    frame(16'h0840, 1);
    s = starts;
    push(12'h0A1);
    push(12'h0A2);
    check("irq at level", {15'h0, irq_b}, 16'h0000);
    push(12'h0A3);
    check("irq on write", {15'h0, irq_b}, 16'h0001);
    push(12'h0A4);
    check("irq again", {15'h0, irq_b}, 16'h0000);
    check("restarts", 16'(starts - s), 16'h0002);
    frame(16'h9800, 1);
    check("oldest entry", rx_w[0], 16'h00A1);
    check("irq on read", {15'h0, irq_b}, 16'h0001);
    frame(16'h9800, 1);
    check("next entry", rx_w[0], 16'h00A2);
  endtask

  task automatic s_full;
    tx_w[0] = 16'hA000;
    frame(16'h0840, 1);
    for (int k = 0; k <= 64; k++)
      push(12'(k));
    frame(16'h8840, 1);
    check("mode flags", {14'h0, rx_w[0][12:11]}, 16'h0002);
    frame(16'h9800, 1);
    check("overwritten head", rx_w[0], 16'h4001);
    // latest result per channel: k = 60..62 on battery, aux one, aux two
    frame(16'h80A0, 4);
    check("battery word", rx_w[0], 16'h003C);
    check("reserved index", rx_w[1], 16'h0000);
    check("aux one word", rx_w[2], 16'h003D);
    check("aux two word", rx_w[3], 16'h003E);
  endtask

  task automatic s_power;
    pdn_b = 1'b0;
    repeat (8) @(negedge clk);
    check("power-down", {15'h0, pdn}, 16'h0001);
    frame(16'h8800, 1);
    check("kept word", rx_w[0], 16'h0400);
    pdn_b = 1'b1;
    repeat (8) @(negedge clk);
    check("powered up", {15'h0, pdn}, 16'h0000);
  endtask

  task automatic s_reset(input logic [15:0] sel_exp);
    check("input select", {12'h0, sel}, sel_exp);
    check("irq idle", {15'h0, irq_b}, 16'h0001);
    check("power-down idle", {15'h0, pdn}, 16'h0000);
    check("out enable idle", {15'h0, miso_oe}, 16'h0000);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (8) @(negedge clk);
    s_reset(16'h0000);
    s_regs();
    s_single();
    s_cont();
    s_full();
    s_power();
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (8) @(negedge clk);
    s_reset(16'h0000);
    frame(16'h8800, 1);
    check("word after reset", rx_w[0], 16'h0000);
    close_out();
  end

  // the sequence needs roughly 15k cycles; a hang gives up after 90k
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    close_out();
  end
endmodule // test_srp_spi_port
`default_nettype wire
